// [logic/tir_pkg.sv]
package tir_pkg;
    // widths and word layout
    localparam int          ID_BITS       = 8;             // identity word length
    localparam int          SYNC_BITS     = 4;             // word sync pattern length
    localparam logic [3:0]  SYNC_PATTERN  = 4'he;          // sync appended after identity bits
    localparam logic [7:0]  ID_CODE_DFLT  = 8'h5a;         // hard-wired code, arbitrary value
    // timing figures
    localparam int          CLK_HZ        = 100_000_000;   // ref_clk rate
    localparam int          LOCK_GAP_MS   = 10;            // tolerated demod lock loss
    localparam int          REPLY_MS      = 35;            // reply burst length
    localparam int          LOCK_GAP_CYC  = CLK_HZ / 1000 * LOCK_GAP_MS;  // longest, rounds down
    localparam int          REPLY_CYC     = CLK_HZ / 1000 * REPLY_MS;     // fixed period
    localparam int          PW_SLOT_CYC   = 300;           // cycles per encoded bit cell
    localparam int          PW_ONE_CYC    = 200;           // high time for a one
    localparam int          PW_ZERO_CYC   = 100;           // high time for a zero
    localparam int          CNT_W         = 24;            // width of long counters
    // reset values
    localparam logic [7:0]  SHIFT_RST     = 8'h00;
    localparam logic [3:0]  SYNC_RST      = 4'h0;
endpackage : tir_pkg

// [logic/tir_enc_if.sv]
`timescale 1ns/1ps
// carries the reply encoder request and its pulse output
interface tir_enc_if;
    logic       run;     // encoder active
    logic [7:0] word;    // identity word to send
    logic       pulse;   // pulse-width-encoded train
    logic       bit_out; // bit being gated out
    modport ctrl (output run, output word, input pulse, input bit_out);
    modport enc  (input run, input word, output pulse, output bit_out);
endinterface : tir_enc_if

// [logic/tir_reply_enc.sv]
`timescale 1ns/1ps
// recirculates the identity word plus sync as pulse-width cells
module tir_reply_enc
    import tir_pkg::*;
(
    input  wire logic  clk,      // ref clock
    input  wire logic  rst_n,    // synchronised reset
    input  wire logic  ce,       // clock enable
    tir_enc_if.enc     bus       // encoder request and output
);
    localparam int FRAME = ID_BITS + SYNC_BITS;
    logic [11:0] frame_q;
    logic [3:0]  idx_q;
    logic [15:0] cell_q;
    wire  [11:0] frame_load = {bus.word, SYNC_PATTERN};
    wire         cur_bit    = frame_q[11];
    wire         cell_end   = (cell_q == 16'(PW_SLOT_CYC - 1));
    wire  [15:0] hi_len     = cur_bit ? 16'(PW_ONE_CYC) : 16'(PW_ZERO_CYC);

    // shift the stored word out msb first, reload after sync
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_q <= 12'h000;
            idx_q   <= 4'h0;
            cell_q  <= 16'h0000;
        end else if (ce) begin
            if (!bus.run) begin
                frame_q <= frame_load;
                idx_q   <= 4'h0;
                cell_q  <= 16'h0000;
            end else if (cell_end) begin
                cell_q <= 16'h0000;
                if (idx_q == 4'(FRAME - 1)) begin
                    frame_q <= frame_load;
                    idx_q   <= 4'h0;
                end else begin
                    frame_q <= {frame_q[10:0], 1'b0};
                    idx_q   <= idx_q + 4'h1;
                end
            end else begin
                cell_q <= cell_q + 16'h0001;
            end
        end
    end

    // width of the high part carries the bit value
    logic pulse_q;
    logic bit_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= 1'b0;
            bit_q   <= 1'b0;
        end else if (ce) begin
            pulse_q <= bus.run && (cell_q < hi_len);
            bit_q   <= bus.run && cur_bit;
        end
    end
    assign bus.pulse   = pulse_q;
    assign bus.bit_out = bit_q;
endmodule : tir_reply_enc

// [logic/tir_transponder_ctrl.sv]
`timescale 1ns/1ps
module tir_transponder_ctrl
    import tir_pkg::*;
#(
    parameter logic [7:0] ID_CODE    = ID_CODE_DFLT,       // plug-in identity code
    parameter int         GAP_CYC    = LOCK_GAP_CYC,       // lock gap tolerance
    parameter int         REPLY_LEN  = REPLY_CYC           // reply burst length
) (
    input  wire logic  ref_clk,          // 100 MHz clock
    input  wire logic  rst_n,            // async reset, active low
    input  wire logic  clk_en,           // freezes all state except the reset synchroniser when low
    input  wire logic  rx_data,          // sliced demodulated bit
    input  wire logic  shift_pulse,      // programmer shift strobe
    input  wire logic  bit_timing_lock,  // programmer in bit lock
    input  wire logic  carrier_lock,     // receiver carrier loop lock
    input  wire logic  demod_lock,       // freq_shift_keying demod lock
    input  wire logic  push_to_talk,     // transmit enable from switch
    input  wire logic  voice_lock,       // voice demod phase lock
    input  wire logic  builtin_check_sw, // press-to-test switch
    input  wire logic  tx_check_ok,      // transmitter radiating level
    input  wire logic  rx_check_ok,      // receiver operating level
    output logic       tx_key,           // transmitter key
    output logic       reply_osc_pwr,    // reply_tone_oscillator power
    output logic       reply_gate,       // oscillator to modulator gate
    output logic       reply_pulse,      // encoded train to shaping filter
    output logic       reply_bit,        // identity bit being sent
    output logic       voice_pwr,        // voice power control
    output logic       headset_pwr,      // earphone driver power
    output logic       check_lamp,       // self-check lamp
    output logic       code_match        // code recognised pulse
);
    // reset release through two flops
    logic rst_s1_q, rst_s2_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire srst_n = rst_s2_q;

    // every pin input except clk_en and rst_n passes two flops before use
    localparam int NIN = 10;
    wire  [NIN-1:0] pin_raw = {rx_data, shift_pulse, bit_timing_lock, carrier_lock,
                               demod_lock, push_to_talk, voice_lock, builtin_check_sw,
                               tx_check_ok, rx_check_ok};
    logic [NIN-1:0] pin_s1_q, pin_s2_q;
    // one process for the whole vector keeps a single driver per register
    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else if (clk_en) begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end
    wire s_data   = pin_s2_q[9];
    wire s_shift  = pin_s2_q[8];
    wire s_btlock = pin_s2_q[7];
    wire s_clock  = pin_s2_q[6];
    wire s_dlock  = pin_s2_q[5];
    wire s_ptt    = pin_s2_q[4];
    wire s_vlock  = pin_s2_q[3];
    wire s_chk    = pin_s2_q[2];
    wire s_txok   = pin_s2_q[1];
    wire s_rxok   = pin_s2_q[0];

    // rising edge of the shift strobe
    logic shift_d1_q;
    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) shift_d1_q <= 1'b0;
        else if (clk_en) shift_d1_q <= s_shift;
    end
    wire shift_evt = s_shift && !shift_d1_q;

    // receive registers: sync window then identity bits
    logic [7:0] rx_sr_q;
    logic [3:0] sync_sr_q;
    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            rx_sr_q   <= SHIFT_RST;
            sync_sr_q <= SYNC_RST;
        end else if (clk_en && shift_evt) begin
            sync_sr_q <= {sync_sr_q[2:0], rx_sr_q[7]};
            rx_sr_q   <= {rx_sr_q[6:0], s_data};
        end
    end

    // bitwise compare against the hard-wired code
    wire [7:0] bit_eq    = ~(rx_sr_q ^ ID_CODE);
    wire       word_sync = (sync_sr_q == SYNC_PATTERN);
    logic      eval_q;
    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) eval_q <= 1'b0;
        else if (clk_en) eval_q <= shift_evt;
    end
    wire recog = eval_q && (&bit_eq) && word_sync && s_clock;

    // lock gap timer: counts demod lock loss
    logic [CNT_W-1:0] gap_q;
    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) gap_q <= '0;
        else if (clk_en) begin
            if (s_dlock) gap_q <= '0;
            else if (gap_q != CNT_W'(GAP_CYC)) gap_q <= gap_q + 1'b1;
        end
    end
    wire gap_long = (gap_q == CNT_W'(GAP_CYC));

    // key latch and reply session
    logic             key_q, reply_q, match_q;
    logic [CNT_W-1:0] rep_q;
    wire rep_done = (rep_q == CNT_W'(REPLY_LEN - 1));
    wire rep_stop = rep_done || gap_long || !s_btlock || !s_clock;
    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            key_q   <= 1'b0;
            reply_q <= 1'b0;
            rep_q   <= '0;
            match_q <= 1'b0;
        end else if (clk_en) begin
            match_q <= recog;
            if (recog) key_q <= 1'b1;
            else if (!s_clock) key_q <= 1'b0;
            if (recog && !reply_q) begin
                reply_q <= 1'b1;
                rep_q   <= '0;
            end else if (reply_q) begin
                if (rep_stop) reply_q <= 1'b0;
                rep_q <= rep_q + 1'b1;
            end
        end
    end

    // reply encoder
    tir_enc_if enc_bus ();
    assign enc_bus.run  = reply_q;
    assign enc_bus.word = ID_CODE;
    tir_reply_enc u_enc (
        .clk   (ref_clk),
        .rst_n (srst_n),
        .ce    (clk_en),
        .bus   (enc_bus.enc)
    );

    // output registers
    always_ff @(posedge ref_clk or negedge srst_n) begin
        if (!srst_n) begin
            tx_key        <= 1'b0;
            reply_osc_pwr <= 1'b0;
            reply_gate    <= 1'b0;
            voice_pwr     <= 1'b0;
            headset_pwr   <= 1'b0;
            check_lamp    <= 1'b0;
        end else if (clk_en) begin
            tx_key        <= key_q || s_ptt || s_chk;
            reply_osc_pwr <= reply_q || s_ptt;
            reply_gate    <= reply_q && (s_dlock || !gap_long);
            voice_pwr     <= s_ptt;
            headset_pwr   <= s_vlock;
            check_lamp    <= s_txok && s_rxok;
        end
    end
    assign reply_pulse = enc_bus.pulse;
    assign reply_bit   = enc_bus.bit_out;
    assign code_match  = match_q;

    // checks
    a_key_on_match: assert property (@(posedge ref_clk) disable iff (!srst_n)
        clk_en && recog |=> key_q) else $error("key not set on match");
    a_key_drop: assert property (@(posedge ref_clk) disable iff (!srst_n)
        clk_en && !recog && !s_clock |=> !key_q) else $error("key held without lock");
    a_match_needs_sync: assert property (@(posedge ref_clk) disable iff (!srst_n)
        recog |-> word_sync && (rx_sr_q == ID_CODE)) else $error("bad match");
    a_shift_only: assert property (@(posedge ref_clk) disable iff (!srst_n)
        !(clk_en && shift_evt) |=> $stable(rx_sr_q)) else $error("shift without pulse");
    a_reply_len: assert property (@(posedge ref_clk) disable iff (!srst_n)
        reply_q && clk_en && rep_done |=> !reply_q) else $error("reply too long");
    a_gap_stop: assert property (@(posedge ref_clk) disable iff (!srst_n)
        clk_en && gap_long && reply_q |=> !reply_q) else $error("reply past gap");
    a_ptt_key: assert property (@(posedge ref_clk) disable iff (!srst_n)
        clk_en && s_ptt |=> tx_key && voice_pwr) else $error("ptt not keyed");
    a_headset: assert property (@(posedge ref_clk) disable iff (!srst_n)
        clk_en |=> headset_pwr == $past(s_vlock)) else $error("headset power wrong");
    a_check_key: assert property (@(posedge ref_clk) disable iff (!srst_n)
        clk_en && s_chk |=> tx_key) else $error("check not keyed");
    a_lamp_and: assert property (@(posedge ref_clk) disable iff (!srst_n)
        clk_en |=> check_lamp == ($past(s_txok) && $past(s_rxok))) else $error("lamp");
    a_no_match_quiet: assert property (@(posedge ref_clk) disable iff (!srst_n)
        !key_q && !s_ptt && !s_chk && clk_en |=> !tx_key) else $error("keyed idle");
    a_osc_pwr: assert property (@(posedge ref_clk) disable iff (!srst_n)
        clk_en && recog |=> ##1 reply_osc_pwr) else $error("osc not powered");
    c_match: cover property (@(posedge ref_clk) recog);
    c_reply_end: cover property (@(posedge ref_clk) reply_q && rep_done);
    c_gap_stop: cover property (@(posedge ref_clk) reply_q && gap_long);
    c_ptt: cover property (@(posedge ref_clk) s_ptt && tx_key);
endmodule : tir_transponder_ctrl

// [dv/tir_interrogator_model.sv]
`timescale 1ns/1ps
// behavioural interrogator: carrier, locks and framed identity bits
module tir_interrogator_model (
    input  wire logic clk,             // ref clock
    output logic      rx_data,         // sliced data bit
    output logic      shift_pulse,     // programmer shift strobe
    output logic      bit_timing_lock, // bit timing lock
    output logic      carrier_lock,    // carrier loop lock
    output logic      demod_lock       // data demod lock
);
    initial begin
        rx_data = 1'b0;
        shift_pulse = 1'b0;
        bit_timing_lock = 1'b0;
        carrier_lock = 1'b0;
        demod_lock = 1'b0;
    end

    // lock levels change only at the falling edge
    task automatic set_locks(input logic car, input logic bt, input logic dm);
        carrier_lock = car;
        bit_timing_lock = bt;
        demod_lock = dm;
    endtask : set_locks

    // short or long dropout of the data demodulator
    task automatic drop_demod(input int n);
        demod_lock = 1'b0;
        repeat (n) @(negedge clk);
        demod_lock = 1'b1;
    endtask : drop_demod

    // msb first; hold sets the pace, so slow senders are covered too
    task automatic send_frame(input logic [11:0] frame, input int hold);
        for (int i = 11; i >= 0; i--) begin
            @(negedge clk);
            rx_data = frame[i];
            repeat (hold) @(negedge clk);
            shift_pulse = 1'b1;
            repeat (hold) @(negedge clk);
            shift_pulse = 1'b0;
        end
        repeat (hold) @(negedge clk);
        rx_data = ~rx_data; // released line must not look like a held bit
    endtask : send_frame
endmodule : tir_interrogator_model

// [dv/tir_transponder_ctrl_tb.sv]
`timescale 1ns/1ps
// sequence bench for the transponder control block
module tir_transponder_ctrl_tb;
    import tir_pkg::*;
    localparam int GAP_T   = 50;   // shortened lock gap
    localparam int REPLY_T = 2000; // shortened reply burst
    logic ref_clk, rst_n, clk_en, rx_data, shift_pulse, bit_timing_lock, carrier_lock;
    logic demod_lock, push_to_talk, voice_lock, builtin_check_sw, tx_check_ok, rx_check_ok;
    logic tx_key, reply_osc_pwr, reply_gate, reply_pulse, reply_bit, voice_pwr;
    logic headset_pwr, check_lamp, code_match, seen;
    int   fails = 0;
    int   n_checks = 0;
    int   wid;
    int   n_match = 0;
    int   mark;

    // the recognition pulse can come before the frame task returns
    always @(negedge ref_clk) begin
        if (code_match === 1'b1) n_match++;
    end

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    tir_interrogator_model u_intr (.clk(ref_clk), .rx_data(rx_data),
        .shift_pulse(shift_pulse), .bit_timing_lock(bit_timing_lock),
        .carrier_lock(carrier_lock), .demod_lock(demod_lock));

    tir_transponder_ctrl #(.GAP_CYC(GAP_T), .REPLY_LEN(REPLY_T)) dut (.ref_clk(ref_clk),
        .rst_n(rst_n), .clk_en(clk_en), .rx_data(rx_data), .shift_pulse(shift_pulse),
        .bit_timing_lock(bit_timing_lock), .carrier_lock(carrier_lock),
        .demod_lock(demod_lock), .push_to_talk(push_to_talk), .voice_lock(voice_lock),
        .builtin_check_sw(builtin_check_sw), .tx_check_ok(tx_check_ok),
        .rx_check_ok(rx_check_ok), .tx_key(tx_key), .reply_osc_pwr(reply_osc_pwr),
        .reply_gate(reply_gate), .reply_pulse(reply_pulse), .reply_bit(reply_bit),
        .voice_pwr(voice_pwr), .headset_pwr(headset_pwr), .check_lamp(check_lamp),
        .code_match(code_match));

    task automatic check(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask : check

    // level inputs pass two sync flops plus logic; eight cycles covers it
    task automatic settle();
        repeat (8) @(negedge ref_clk);
    endtask : settle

    // bounded watch for the one-cycle recognition pulse
    task automatic wait_match();
        repeat (40) @(negedge ref_clk);
        seen = (n_match != mark);
    endtask : wait_match

    task automatic wait_pulse(input logic lvl);
        repeat (400) if (reply_pulse !== lvl) @(negedge ref_clk);
    endtask : wait_pulse

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // watchdog, well beyond the expected run
    initial begin
        #400_000;
        fails++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        push_to_talk = 1'b0;
        voice_lock = 1'b0;
        builtin_check_sw = 1'b0;
        tx_check_ok = 1'b0;
        rx_check_ok = 1'b0;
        repeat (20) @(negedge ref_clk);
        check("tx_key in reset", 1'b0, tx_key);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        u_intr.set_locks(1'b1, 1'b1, 1'b1);
        // foreign identity, then own identity with broken sync
        for (int k = 0; k < 2; k++) begin
            mark = n_match;
            u_intr.send_frame(k == 0 ? {SYNC_PATTERN, ~ID_CODE_DFLT}
                                     : {~SYNC_PATTERN, ID_CODE_DFLT}, 2);
            wait_match();
            check("code_match bad frame", 1'b0, seen);
            check("tx_key bad frame", 1'b0, tx_key);
        end
        // own identity at a slow pace
        mark = n_match;
        u_intr.send_frame({SYNC_PATTERN, ID_CODE_DFLT}, 5);
        wait_match();
        check("code_match", 1'b1, seen);
        check("tx_key", 1'b1, tx_key);
        check("reply_osc_pwr", 1'b1, reply_osc_pwr);
        check("reply_gate", 1'b1, reply_gate);
        // second cell holds a one of the identity: long high time
        wait_pulse(1'b0);
        wait_pulse(1'b1);
        wid = 0;
        while (reply_pulse === 1'b1 && wid < 400) begin
            @(negedge ref_clk);
            wid++;
            if (wid == PW_ZERO_CYC) check("reply_bit", 1'b1, reply_bit);
        end
        check("one cell width", 1'b1, wid == PW_ONE_CYC);
        repeat (REPLY_T) @(negedge ref_clk);
        check("reply_gate after burst", 1'b0, reply_gate);
        check("reply_osc_pwr after burst", 1'b0, reply_osc_pwr);
        check("tx_key held", 1'b1, tx_key);
        u_intr.set_locks(1'b0, 1'b1, 1'b1);
        settle();
        check("tx_key carrier lost", 1'b0, tx_key);
        u_intr.set_locks(1'b1, 1'b1, 1'b1);
        // short gap, long gap, bit timing loss during a reply
        for (int k = 0; k < 3; k++) begin
            u_intr.send_frame({SYNC_PATTERN, ID_CODE_DFLT}, 2);
            wait_match();
            if (k == 2) u_intr.set_locks(1'b1, 1'b0, 1'b1);
            else u_intr.drop_demod(k == 0 ? GAP_T - 30 : GAP_T + 30);
            settle();
            check("reply_gate after loss", k == 0, reply_gate);
            u_intr.set_locks(1'b0, 1'b1, 1'b1);
            settle();
            u_intr.set_locks(1'b1, 1'b1, 1'b1);
        end
        // push-to-talk, press-to-test and voice lock levels
        for (int k = 1; k >= 0; k--) begin
            push_to_talk = k[0];
            settle();
            check("tx_key talk", k[0], tx_key);
            check("voice_pwr", k[0], voice_pwr);
            builtin_check_sw = k[0];
            push_to_talk = 1'b0;
            settle();
            check("tx_key self check", k[0], tx_key);
            builtin_check_sw = 1'b0;
            voice_lock = k[0];
            settle();
            check("headset_pwr", k[0], headset_pwr);
        end
        // clock enable low freezes the key path
        clk_en = 1'b0;
        push_to_talk = 1'b1;
        settle();
        check("tx_key frozen", 1'b0, tx_key);
        clk_en = 1'b1;
        settle();
        check("tx_key unfrozen", 1'b1, tx_key);
        push_to_talk = 1'b0;
        settle();
        for (int k = 0; k < 4; k++) begin
            tx_check_ok = k[1];
            rx_check_ok = k[0];
            settle();
            check("check_lamp", k == 3, check_lamp);
        end
        print_verdict();
    end
endmodule : tir_transponder_ctrl_tb
